/* File: mtb_pkg.sv */
package mtb_pkg;

  // Time base and burst figures.
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned TICK_TIME_NS    = 1000;
  localparam int unsigned TICK_CYCLES     =
    (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SUBTICK_DIV     = 64;
  localparam int unsigned SUBTICK_W       = 6;
  localparam int unsigned TICK_W          = 26;
  localparam int unsigned JITTER_LIMIT_NS = 500;
  localparam int unsigned STAMP_SCALE     = 4;
  localparam int unsigned MIN_INFO_BYTES  = 6;
  localparam int unsigned PRESC_W         = 16;
  localparam int unsigned SLOT_W          = 16;
  localparam int unsigned BYTE_W          = 16;
  localparam int unsigned CODE_W          = 4;

  // Profile code used by grouped contention slots.
  localparam logic [3:0] REQ_INTERVAL_CODE = 4'h1;

  // Physical layer type encodings.
  typedef enum logic [1:0] {
    MTB_PHY_BURST_TDD  = 2'h0,
    MTB_PHY_BURST_FDD  = 2'h1,
    MTB_PHY_CONTINUOUS = 2'h2
  } mtb_phy_t;

  // Burst description from the scheduler.
  typedef struct packed {
    logic [15:0] slots;
    logic [15:0] slots_per_block;
    logic [15:0] block_bytes;
    logic [15:0] parity_bytes;
    logic [15:0] bytes_per_slot;
    logic [3:0]  profile_code;
    logic        contention;
  } mtb_burst_req_t;

  // Allocation result and map entry.
  typedef struct packed {
    logic [15:0] start_slot;
    logic [15:0] slots;
    logic [3:0]  profile_code;
    logic [15:0] whole_blocks;
    logic [15:0] rem_slots;
    logic [15:0] short_payload;
    logic        shortened;
  } mtb_map_entry_t;

endpackage

/* File: mtb_burst_split.sv */
`timescale 1ns/1ps
// Divides a burst into whole FEC blocks and a remainder by repeated
// subtraction, one step per clock, so no wide divider is needed.
module mtb_burst_split (
  // Clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   reset_in,
  // Request
  input  wire logic                   start_in,
  input  wire mtb_pkg::mtb_burst_req_t req_in,
  // Result
  output logic                        busy_out,
  output logic                        done_out,
  output logic                        ok_out,
  output logic [15:0]                 blocks_out,
  output logic [15:0]                 rem_out,
  output logic [15:0]                 payload_out
);

  typedef enum logic [2:0] {
    MTB_S_IDLE = 3'b001,
    MTB_S_DIV  = 3'b010,
    MTB_S_FIN  = 3'b100
  } mtb_split_state_t;

  mtb_split_state_t        state_reg;
  mtb_pkg::mtb_burst_req_t req_reg;
  logic [15:0]             left_reg;
  logic [15:0]             blocks_reg;
  logic [31:0]             rem_bytes;

  assign busy_out  = (state_reg != MTB_S_IDLE);
  assign rem_bytes = left_reg * req_reg.bytes_per_slot;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg  <= MTB_S_IDLE;
      req_reg    <= '0;
      left_reg   <= 16'h0000;
      blocks_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        MTB_S_IDLE: begin
          if (start_in) begin
            req_reg    <= req_in;
            left_reg   <= req_in.slots;
            blocks_reg <= 16'h0000;
            state_reg  <= MTB_S_DIV;
          end
        end
        MTB_S_DIV: begin
          // p = k*n + j by subtraction.
          if (req_reg.slots_per_block != 16'h0000 &&
              left_reg >= req_reg.slots_per_block) begin
            left_reg   <= left_reg - req_reg.slots_per_block;
            blocks_reg <= blocks_reg + 16'h0001;
          end else begin
            state_reg <= MTB_S_FIN;
          end
        end
        MTB_S_FIN: state_reg <= MTB_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      done_out    <= 1'b0;
      ok_out      <= 1'b0;
      blocks_out  <= 16'h0000;
      rem_out     <= 16'h0000;
      payload_out <= 16'h0000;
    end else begin
      done_out <= (state_reg == MTB_S_FIN);
      if (state_reg == MTB_S_FIN) begin
        blocks_out  <= blocks_reg;
        rem_out     <= left_reg;
        payload_out <= (rem_bytes[15:0] > req_reg.parity_bytes) ?
                       rem_bytes[15:0] - req_reg.parity_bytes : 16'h0000;
        // Both zero refused; a short block must beat parity and
        // keep the least information bytes.
        ok_out <= !(blocks_reg == 16'h0000 && left_reg == 16'h0000) &&
                  (left_reg == 16'h0000 ||
                   (rem_bytes[15:0] > req_reg.parity_bytes &&
                    (rem_bytes[15:0] - req_reg.parity_bytes) >=
                    16'(mtb_pkg::MIN_INFO_BYTES)));
      end
    end
  end

  AST_SPLIT_DONE: assert property (@(posedge clock_in)
    disable iff (reset_in)
    state_reg == MTB_S_FIN |=> done_out)
    else $error("Split did not finish.");

  AST_SPLIT_NONZERO: assert property (@(posedge clock_in)
    disable iff (reset_in)
    done_out && ok_out |-> (blocks_out != 16'h0000 || rem_out != 16'h0000))
    else $error("Empty split accepted.");

endmodule

/* File: mtb_timebase.sv */
`timescale 1ns/1ps
module mtb_timebase #(
  parameter int unsigned DIV_DEFAULT = 10
) (
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    reset_in,
  // Configuration
  input  wire logic [15:0]             slot_div_in,
  input  wire mtb_pkg::mtb_phy_t       phy_type_in,
  input  wire logic [15:0]             frame_slots_in,
  input  wire logic [15:0]             tx_to_rx_gap_in,
  input  wire logic [15:0]             rx_to_tx_gap_in,
  // Allocation requests
  input  wire logic                    alloc_valid_in,
  input  wire mtb_pkg::mtb_burst_req_t alloc_req_in,
  output logic                         alloc_ready_out,
  // Uplink processing progress
  input  wire logic                    ack_valid_in,
  input  wire logic [15:0]             ack_slot_in,
  // Map output
  output logic                         map_valid_out,
  output mtb_pkg::mtb_map_entry_t      map_entry_out,
  output logic                         alloc_error_out,
  // Time base
  output logic [25:0]                  tick_count_out,
  output logic [5:0]                   subtick_out,
  output logic [15:0]                  slot_count_out,
  output logic [31:0]                  timestamp_out,
  output logic [15:0]                  ack_time_out,
  output logic [1:0]                   phy_type_out,
  // Frame timing
  output logic                         frame_start_out,
  output logic                         preamble_out,
  output logic                         tx_to_rx_gap_out,
  output logic                         rx_to_tx_gap_out
);

  localparam int unsigned SUB_CYC =
    (mtb_pkg::TICK_CYCLES / mtb_pkg::SUBTICK_DIV) > 0 ?
    (mtb_pkg::TICK_CYCLES / mtb_pkg::SUBTICK_DIV) : 1;
  localparam logic [7:0] SUB_LAST = 8'(SUB_CYC - 1);
  localparam logic [15:0] DIV_DEF = 16'(DIV_DEFAULT);

  logic [7:0]  sub_cyc_reg;
  logic [5:0]  subtick_reg;
  logic [25:0] tick_reg;
  logic [15:0] presc_reg;
  logic [15:0] slot_reg;
  logic [15:0] div_reg;
  logic [15:0] frame_pos_reg;
  logic [15:0] ack_reg;
  logic [15:0] next_start_reg;
  logic        tick_pulse;
  logic        slot_pulse;
  logic        sub_pulse;
  logic        burst_mode;
  logic        split_busy;
  logic        split_done;
  logic        split_ok;
  logic [15:0] split_blocks;
  logic [15:0] split_rem;
  logic [15:0] split_payload;
  logic        split_start;
  mtb_pkg::mtb_burst_req_t req_reg;

  // Sub-tick cycles do not divide evenly at this clock; the final
  // sub-tick absorbs the leftover cycles so that the tick stays exact.
  assign sub_pulse  = (sub_cyc_reg == SUB_LAST) && (subtick_reg != 6'h3F);
  assign tick_pulse = (sub_cyc_reg >= 8'(mtb_pkg::TICK_CYCLES -
                       SUB_CYC * (mtb_pkg::SUBTICK_DIV - 1) - 1)) &&
                      (subtick_reg == 6'h3F);
  assign slot_pulse = tick_pulse && (presc_reg == div_reg - 16'h0001);
  assign burst_mode = (phy_type_in != mtb_pkg::MTB_PHY_CONTINUOUS);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sub_cyc_reg <= 8'h00;
      subtick_reg <= 6'h00;
    end else if (sub_pulse || tick_pulse) begin
      sub_cyc_reg <= 8'h00;
      subtick_reg <= subtick_reg + 6'h01;
    end else begin
      sub_cyc_reg <= sub_cyc_reg + 8'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tick_reg <= 26'h0000000;
    end else if (tick_pulse) begin
      tick_reg <= tick_reg + 26'h0000001;
    end
  end

  // Divisor is taken at slot boundaries only, so a write mid-slot
  // cannot leave the prescaler beyond its terminal count.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      div_reg <= DIV_DEF;
    end else if (tick_pulse && presc_reg == div_reg - 16'h0001) begin
      div_reg <= (slot_div_in == 16'h0000) ? 16'h0001 :
                 slot_div_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      presc_reg <= 16'h0000;
      slot_reg  <= 16'h0000;
    end else if (tick_pulse) begin
      if (presc_reg >= div_reg - 16'h0001) begin
        presc_reg <= 16'h0000;
        slot_reg  <= slot_reg + 16'h0001;
      end else begin
        presc_reg <= presc_reg + 16'h0001;
      end
    end
  end

  // Frame position in mini-slots; gaps and preamble fall on slot edges.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      frame_pos_reg <= 16'h0000;
    end else if (slot_pulse) begin
      if (frame_pos_reg >= frame_slots_in - 16'h0001) begin
        frame_pos_reg <= 16'h0000;
      end else begin
        frame_pos_reg <= frame_pos_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      frame_start_out  <= 1'b0;
      preamble_out     <= 1'b0;
      tx_to_rx_gap_out <= 1'b0;
      rx_to_tx_gap_out <= 1'b0;
    end else begin
      frame_start_out <= burst_mode && slot_pulse &&
                         frame_pos_reg >= frame_slots_in - 16'h0001;
      if (slot_pulse) begin
        preamble_out <= burst_mode &&
                        frame_pos_reg >= frame_slots_in - 16'h0001;
        // Gaps occupy whole slots at the frame end in TDD.
        tx_to_rx_gap_out <= (phy_type_in == mtb_pkg::MTB_PHY_BURST_TDD) &&
          frame_pos_reg + 16'h0001 >= frame_slots_in - rx_to_tx_gap_in -
          tx_to_rx_gap_in &&
          frame_pos_reg + 16'h0001 < frame_slots_in - rx_to_tx_gap_in;
        rx_to_tx_gap_out <= (phy_type_in == mtb_pkg::MTB_PHY_BURST_TDD) &&
          frame_pos_reg + 16'h0001 >= frame_slots_in - rx_to_tx_gap_in &&
          frame_pos_reg + 16'h0001 < frame_slots_in;
      end
    end
  end

  // Timestamp is tick and sub-tick straight from the counters, with no
  // allowance for later media stages.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tick_count_out <= 26'h0000000;
      subtick_out    <= 6'h00;
      slot_count_out <= 16'h0000;
      timestamp_out  <= 32'h00000000;
      phy_type_out   <= 2'h0;
    end else begin
      tick_count_out <= tick_reg;
      subtick_out    <= subtick_reg;
      slot_count_out <= slot_reg;
      timestamp_out  <= {tick_reg, subtick_reg};
      phy_type_out   <= phy_type_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ack_reg <= 16'h0000;
    end else if (ack_valid_in && ack_slot_in > ack_reg) begin
      ack_reg <= ack_slot_in;
    end
  end
  assign ack_time_out = ack_reg;

  assign alloc_ready_out = !split_busy && !split_done && !map_valid_out;
  assign split_start     = alloc_valid_in && alloc_ready_out;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      req_reg <= '0;
    end else if (split_start) begin
      req_reg <= alloc_req_in;
      if (alloc_req_in.contention) begin
        req_reg.profile_code <= mtb_pkg::REQ_INTERVAL_CODE;
      end
    end
  end

  mtb_burst_split u_split (
    .clock_in    (clock_in),
    .reset_in    (reset_in),
    .start_in    (split_start),
    .req_in      (alloc_req_in),
    .busy_out    (split_busy),
    .done_out    (split_done),
    .ok_out      (split_ok),
    .blocks_out  (split_blocks),
    .rem_out     (split_rem),
    .payload_out (split_payload)
  );

  // Entries are issued in request order, each starting where the last
  // ended or at the current slot if that is later, so the map is always in time order.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      map_valid_out   <= 1'b0;
      map_entry_out   <= '0;
      alloc_error_out <= 1'b0;
      next_start_reg  <= 16'h0000;
    end else begin
      map_valid_out   <= split_done && split_ok;
      alloc_error_out <= split_done && !split_ok;
      if (split_done && split_ok) begin
        map_entry_out.start_slot    <= (next_start_reg > slot_reg) ?
                                       next_start_reg : slot_reg;
        map_entry_out.slots         <= req_reg.slots;
        map_entry_out.profile_code  <= req_reg.profile_code;
        map_entry_out.whole_blocks  <= split_blocks;
        map_entry_out.rem_slots     <= split_rem;
        map_entry_out.short_payload <= split_payload;
        map_entry_out.shortened     <= (split_rem != 16'h0000);
        next_start_reg <= ((next_start_reg > slot_reg) ?
                           next_start_reg : slot_reg) + req_reg.slots;
      end
    end
  end

  AST_TICK_ADVANCE: assert property (@(posedge clock_in)
    disable iff (reset_in)
    tick_pulse |=> tick_reg == $past(tick_reg) + 26'h0000001)
    else $error("Tick counter did not advance.");

  AST_SLOT_ON_WRAP: assert property (@(posedge clock_in)
    disable iff (reset_in)
    !tick_pulse |=> slot_reg == $past(slot_reg))
    else $error("Slot count moved without a tick.");

  AST_PRESC_RANGE: assert property (@(posedge clock_in)
    disable iff (reset_in)
    presc_reg < div_reg)
    else $error("Prescaler beyond divisor.");

  AST_CONTENTION_CODE: assert property (@(posedge clock_in)
    disable iff (reset_in)
    split_start && alloc_req_in.contention |=>
    req_reg.profile_code == mtb_pkg::REQ_INTERVAL_CODE)
    else $error("Contention burst lost its profile code.");

  AST_MAP_ORDER: assert property (@(posedge clock_in)
    disable iff (reset_in)
    map_valid_out |-> next_start_reg ==
    map_entry_out.start_slot + map_entry_out.slots)
    else $error("Map entry out of time order.");

  AST_PREAMBLE_FRAME: assert property (@(posedge clock_in)
    disable iff (reset_in)
    frame_start_out |-> preamble_out)
    else $error("Frame started without preamble.");

  AST_ACK_MONO: assert property (@(posedge clock_in)
    disable iff (reset_in)
    ack_time_out >= $past(ack_time_out))
    else $error("Ack time went backwards.");

  AST_GAP_SLOT_EDGE: assert property (@(posedge clock_in)
    disable iff (reset_in)
    $rose(rx_to_tx_gap_out) |-> $past(slot_pulse))
    else $error("Gap began off a slot edge.");

endmodule

/* File: mtb_sched_model.sv */
`timescale 1ns/1ps
// Scheduler side of the allocation handshake. A request is held until the
// edge at which ready is seen high; afterwards the bus carries the inverse
// so that a late sample can never match the old request by accident.
module mtb_sched_model (
  // Clock
  input  wire logic               clock_in,
  // Handshake
  input  wire logic               alloc_ready_in,
  output logic                    alloc_valid_out,
  output mtb_pkg::mtb_burst_req_t alloc_req_out
);
  initial begin
    alloc_valid_out = 1'b0;
    alloc_req_out   = '0;
  end

  task automatic send(input mtb_pkg::mtb_burst_req_t req);
    @(posedge clock_in);
    #1;
    alloc_req_out   = req;
    alloc_valid_out = 1'b1;
    do @(posedge clock_in); while (alloc_ready_in !== 1'b1);
    #1;
    alloc_valid_out = 1'b0;
    alloc_req_out   = ~req;
  endtask

  // Station side of the map. A lower profile code counts as the more
  // robust one; this station has negotiated OWN_CODE.
  localparam logic [3:0]  OWN_CODE   = 4'h7;
  localparam logic [15:0] TX_ADVANCE = 16'h0000;
  localparam logic [15:0] STG_SLOTS  = 16'h0001;

  // A portion is heard when robust enough; a half-duplex station also
  // skips it when, shifted by its advance, it meets its own uplink.
  function automatic logic hears(input logic [3:0]  code,
                                 input logic        half,
                                 input logic [15:0] dl_start,
                                 input logic [15:0] ul_end);
    logic meets;
    meets = (dl_start + TX_ADVANCE) < ul_end;
    return (code <= OWN_CODE) && !(half && meets);
  endfunction

  // The receiver wakes only for its own bursts, and only in time if the
  // burst has not begun by the time the map arrives.
  function automatic logic wakes(input logic [15:0] start,
                                 input logic [15:0] now,
                                 input logic        mine);
    return mine && (start >= now);
  endfunction

  // Each station opens its allocation with the transition gap: ramp
  // down of the previous sender, then its own preamble.
  function automatic logic [15:0] data_slots(input logic [15:0] slots);
    return (slots > STG_SLOTS) ? slots - STG_SLOTS : 16'h0000;
  endfunction
endmodule

/* File: minislot_timebase_burst_alloc_tb.sv */
`timescale 1ns/1ps
module minislot_timebase_burst_alloc_tb;
  logic                    clock_in        = 1'b0;
  logic                    reset_in        = 1'b1;
  logic [15:0]             slot_div_in     = 16'h0003;
  mtb_pkg::mtb_phy_t       phy_type_in     = mtb_pkg::MTB_PHY_BURST_TDD;
  logic [15:0]             frame_slots_in  = 16'h0004;
  logic [15:0]             tx_to_rx_gap_in = 16'h0001;
  logic [15:0]             rx_to_tx_gap_in = 16'h0001;
  logic                    ack_valid_in    = 1'b0;
  logic [15:0]             ack_slot_in     = 16'h0000;
  logic                    alloc_valid;
  mtb_pkg::mtb_burst_req_t alloc_req;
  logic                    alloc_ready_out;
  logic                    map_valid_out;
  mtb_pkg::mtb_map_entry_t map_entry_out;
  logic                    alloc_error_out;
  logic [25:0]             tick_count_out;
  logic [5:0]              subtick_out;
  logic [15:0]             slot_count_out;
  logic [31:0]             timestamp_out;
  logic [15:0]             ack_time_out;
  logic [1:0]              phy_type_out;
  logic                    frame_start_out;
  logic                    preamble_out;
  logic                    tx_to_rx_gap_out;
  logic                    rx_to_tx_gap_out;
  int                      n_errors        = 0;
  int                      samples_checked = 0;
  int                      cycles          = 0;
  logic [15:0]             prev_end        = 16'h0000;
  logic [15:0]             lfsr            = 16'h0061;

  always #2.5 clock_in = ~clock_in;

  mtb_timebase dut_u (
    .clock_in(clock_in), .reset_in(reset_in), .slot_div_in(slot_div_in),
    .phy_type_in(phy_type_in), .frame_slots_in(frame_slots_in),
    .tx_to_rx_gap_in(tx_to_rx_gap_in), .rx_to_tx_gap_in(rx_to_tx_gap_in),
    .alloc_valid_in(alloc_valid), .alloc_req_in(alloc_req),
    .alloc_ready_out(alloc_ready_out), .ack_valid_in(ack_valid_in),
    .ack_slot_in(ack_slot_in), .map_valid_out(map_valid_out),
    .map_entry_out(map_entry_out), .alloc_error_out(alloc_error_out),
    .tick_count_out(tick_count_out), .subtick_out(subtick_out),
    .slot_count_out(slot_count_out), .timestamp_out(timestamp_out),
    .ack_time_out(ack_time_out), .phy_type_out(phy_type_out),
    .frame_start_out(frame_start_out), .preamble_out(preamble_out),
    .tx_to_rx_gap_out(tx_to_rx_gap_out),
    .rx_to_tx_gap_out(rx_to_tx_gap_out));

  mtb_sched_model sched_u (
    .clock_in(clock_in), .alloc_ready_in(alloc_ready_out),
    .alloc_valid_out(alloc_valid), .alloc_req_out(alloc_req));

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic step();
    @(posedge clock_in);
    #1;
  endtask

  // Expectations come from p = k*n + j and the size limits of a short block.
  task automatic burst(input logic [15:0] p, input logic [15:0] n,
                       input logic [15:0] bps, input logic [15:0] par,
                       input logic [3:0] code, input logic cont);
    mtb_pkg::mtb_burst_req_t r;
    int k;
    int j;
    int bytes;
    logic bad;
    logic [3:0] pc;
    r = '{p, n, n * bps, par, bps, code, cont};
    pc = cont ? mtb_pkg::REQ_INTERVAL_CODE : code;
    k = p / n;
    j = p % n;
    bytes = j * bps;
    bad = (k == 0 && j == 0) || (j != 0 && (bytes <= par || bytes - par < 6));
    sched_u.send(r);
    for (int i = 0; i < 600; i++) begin
      step();
      if (map_valid_out === 1'b1 || alloc_error_out === 1'b1) break;
    end
    chk("refused", bad, alloc_error_out);
    chk("answered", !bad, map_valid_out);
    if (!bad) begin
      chk("slots", p, map_entry_out.slots);
      chk("profile", pc, map_entry_out.profile_code);
      chk("hears", pc <= 4'h7, sched_u.hears(map_entry_out.profile_code,
          1'b0, map_entry_out.start_slot, prev_end));
      chk("half hears", pc <= 4'h7, sched_u.hears(
          map_entry_out.profile_code, 1'b1, map_entry_out.start_slot,
          prev_end));
      chk("wake", 1, sched_u.wakes(map_entry_out.start_slot,
          slot_count_out, 1'b1));
      chk("station data", (p > 16'h0001) ? p - 16'h0001 : 16'h0000,
          sched_u.data_slots(map_entry_out.slots));
      chk("blocks", k, map_entry_out.whole_blocks);
      chk("remainder", j, map_entry_out.rem_slots);
      chk("shortened", j != 0, map_entry_out.shortened);
      if (j != 0) begin
        chk("payload", bytes - par, map_entry_out.short_payload);
      end
      chk("time order", 1,
          map_entry_out.start_slot >= prev_end);
      prev_end = map_entry_out.start_slot + p;
    end
  endtask

  task automatic ack(input logic [15:0] v, input logic [15:0] exp);
    ack_slot_in  = v;
    ack_valid_in = 1'b1;
    step();
    ack_valid_in = 1'b0;
    repeat (3) step();
    chk("ack time", exp, ack_time_out);
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    int cnt;
    int gaps;
    int pre;
    logic [25:0] t0;
    logic [15:0] s0;
    logic [31:0] ts0;
    repeat (10) step();
    chk("reset tick", 0, tick_count_out);
    chk("reset slot", 0, slot_count_out);
    reset_in = 1'b0;
    for (int m = 0; m < 3; m++) begin
      phy_type_in = mtb_pkg::mtb_phy_t'(m);
      cnt = 0;
      repeat (5000) begin
        step();
        cnt += frame_start_out;
      end
      chk("phy type", m, phy_type_out);
      chk("frames", m != 2, cnt != 0);
    end
    $display("test phy modes done");
    phy_type_in = mtb_pkg::MTB_PHY_BURST_TDD;
    t0 = tick_count_out;
    ts0 = timestamp_out;
    repeat (2000) step();
    chk("ticks", t0 + 26'h000000A, tick_count_out);
    chk("stamp", {tick_count_out, subtick_out},
        timestamp_out);
    chk("stamp rate", ts0 + 32'h00000280, timestamp_out);
    s0 = slot_count_out;
    for (int i = 0; i < 700 && slot_count_out === s0; i++) step();
    s0 = slot_count_out;
    repeat (3000) step();
    chk("slots", s0 + 16'h0005, slot_count_out);
    $display("test time base done");
    for (int i = 0; i < 3000 && frame_start_out !== 1'b1; i++) step();
    cnt = 0;
    gaps = 0;
    pre = 0;
    do begin
      step();
      cnt++;
      gaps += tx_to_rx_gap_out + rx_to_tx_gap_out;
      pre += preamble_out;
    end while (frame_start_out !== 1'b1 && cnt < 5000);
    chk("frame length", 2400, cnt);
    chk("gap cycles", 1200, gaps);
    chk("preamble", 1, pre != 0);
    $display("test framing done");
    ack(16'h0014, 16'h0014);
    ack(16'h000A, 16'h0014);
    $display("test ack done");
    burst(16'h0000, 16'h0004, 16'h0008, 16'h0002, 4'h3, 1'b0);
    burst(16'h0007, 16'h0004, 16'h0001, 16'h0003, 4'h3, 1'b0);
    burst(16'h0005, 16'h0004, 16'h0007, 16'h0002, 4'h5, 1'b0);
    burst(16'h0005, 16'h0004, 16'h0008, 16'h0002, 4'h5, 1'b0);
    burst(16'h0008, 16'h0004, 16'h0003, 16'h0001, 4'h9, 1'b0);
    burst(16'h0003, 16'h0004, 16'h0009, 16'h0003, 4'h2, 1'b0);
    burst(16'h0006, 16'h0002, 16'h0004, 16'h0001, 4'h7, 1'b1);
    for (int i = 0; i < 30; i++) begin
      lfsr = lfsr_step(lfsr);
      s0 = lfsr_step(lfsr);
      lfsr = lfsr_step(s0);
      burst({8'h00, lfsr[7:0]}, {12'h000, s0[3:0]} + 16'h0001,
            {12'h000, s0[7:4]} + 16'h0001, {11'h000, s0[12:8]},
            lfsr[11:8], lfsr[12]);
    end
    $display("test bursts done");
    finish_test();
  end
endmodule
